// [rtl/drw_dev.sv]
// Controller end: refresh sequencer and CPU wait output
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module drw_dev (
   drw_if.dev bus,
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic prog_i,
   input wire logic [2:0] ras_cas_config_bits_i,
   input wire logic staggered_select_bit_i,
   input wire logic [1:0] ras_low_i,
   input wire logic [1:0] precharge_i,
   input wire logic wait_type_select_bit_i,
   input wire logic [1:0] wait_delay_bits_i,
   input wire logic page_mode_i,
   input wire logic dual_port_i,
   output logic [drw_pkg::CNT_W-1:0] refresh_addr_o,
   output logic wait_o
);
   typedef struct packed {
      drw_pkg::drw_ref_t st;
      logic stag;
      logic ack_mode;
      logic page;
      logic dual;
      logic [1:0] dly;
      logic [1:0] grp;
      logic scrub;
      logic [1:0] rlow;
      logic [1:0] pre;
      logic [2:0] step;
      logic [3:0] on;
      logic [3:0] cas;
      logic [3:0][2:0] cnt;
      logic [drw_pkg::CNT_W-1:0] addr;
      logic [15:0] timer;
      logic [4:0] hold;
      logic pend;
      logic rq_d;
   } drw_dst_t;
   drw_dst_t s;
   drw_dst_t next_s;
   logic hold_w;
   ////////////////////////////////////////////////////////////////////////
   // Column strobes chosen from bank bits and configuration
   function automatic logic [3:0] scrub_cas(input logic [1:0] grp,
                                            input logic [1:0] bank);
      case (grp)
         drw_pkg::RAS_ALL: scrub_cas = 4'hf;
         drw_pkg::RAS_PAIR: scrub_cas = bank[0] ? 4'hc : 4'h3;
         default: scrub_cas = 4'h1 << bank;
      endcase
   endfunction
   ////////////////////////////////////////////////////////////////////////
   // Refresh sequencing, counter and request timer
   always_comb begin
      logic [1:0] bank;
      logic [drw_pkg::CNT_W-1:0] inc;
      logic set_pend;
      bank = 2'h0;
      inc = '0;
      set_pend = 1'b0;
      next_s = s;
      if (prog_i) begin
         // Latch configuration at programming
         next_s.grp = ras_cas_config_bits_i[1:0] == 2'h3 ? drw_pkg::RAS_ALL
                      : {1'b0, ras_cas_config_bits_i[0]};
         next_s.stag = staggered_select_bit_i;
         next_s.scrub = !staggered_select_bit_i &&
                        !ras_cas_config_bits_i[2];
         next_s.rlow = ras_low_i;
         next_s.pre = precharge_i;
         next_s.ack_mode = wait_type_select_bit_i;
         next_s.dly = wait_delay_bits_i;
         next_s.page = page_mode_i;
         next_s.dual = dual_port_i;
      end
      // Request timer, cleared by a long external request
      next_s.rq_d = bus.external_refresh_request_in;
      if (bus.external_refresh_request_in &&
          !bus.disable_auto_refresh_in) begin
         if (!s.rq_d) begin
            next_s.addr = drw_pkg::CNT_RST;
         end
         if (s.hold < 5'(drw_pkg::CLR_CYC - 1)) begin
            next_s.hold = s.hold + 5'h1;
         end else begin
            next_s.timer = 16'h0000;
            next_s.addr = drw_pkg::CNT_RST;
         end
      end else begin
         next_s.hold = 5'h00;
         if (s.timer >= 16'(drw_pkg::REF_CYC - 1)) begin
            next_s.timer = 16'h0000;
            if (!bus.disable_auto_refresh_in) begin
               set_pend = 1'b1;
            end
         end else begin
            next_s.timer = s.timer + 16'h0001;
         end
      end
      if (bus.external_refresh_request_in && bus.disable_auto_refresh_in) begin
         set_pend = 1'b1;
      end
      case (s.st)
         drw_pkg::ST_IDLE: begin
            if (s.pend && !bus.access_request_in) begin
               next_s.st = drw_pkg::ST_PRE;
               next_s.step = 3'h0;
            end
         end
         drw_pkg::ST_PRE: begin
            next_s.st = drw_pkg::ST_LOW;
            next_s.step = 3'h1;
            if (!s.stag || s.grp == drw_pkg::RAS_ALL) begin
               next_s.on = 4'hf;
            end else if (s.grp == drw_pkg::RAS_PAIR) begin
               next_s.on = 4'h3;
            end else begin
               next_s.on = 4'h1;
            end
            for (int i = 0; i < 4; i++) begin
               next_s.cnt[i] = next_s.on[i] ? {1'b0, s.rlow} : 3'h0;
            end
            bank = s.dual ? s.addr[drw_pkg::BANK_LSB +: 2]
                   : s.addr[drw_pkg::SP_BANK_LSB +: 2];
            if (s.scrub) begin
               next_s.cas = scrub_cas(s.grp, bank);
            end
         end
         drw_pkg::ST_LOW: begin
            // Stagger remaining groups one per edge
            if (s.stag && s.grp != drw_pkg::RAS_ALL && s.step < 3'h4) begin
               if (s.grp == drw_pkg::RAS_PAIR && s.step == 3'h1) begin
                  next_s.on[3:2] = 2'h3;
                  next_s.cnt[2] = {1'b0, s.rlow};
                  next_s.cnt[3] = {1'b0, s.rlow};
               end else if (s.grp == drw_pkg::RAS_SINGLE) begin
                  next_s.on[s.step[1:0]] = 1'b1;
                  next_s.cnt[s.step[1:0]] = {1'b0, s.rlow};
               end
               next_s.step = s.step + 3'h1;
            end
            for (int i = 0; i < 4; i++) begin
               if (s.on[i]) begin
                  if (s.cnt[i] != 3'h0) begin
                     next_s.cnt[i] = s.cnt[i] - 3'h1;
                  end else if (!(bus.extend_refresh_in && !s.stag)) begin
                     next_s.on[i] = 1'b0;
                  end
               end
            end
            if (next_s.on == 4'h0 && s.step != 3'h0 &&
                (!s.stag || s.grp == drw_pkg::RAS_ALL || s.step >= 3'h4 ||
                 (s.grp == drw_pkg::RAS_PAIR && s.step >= 3'h2))) begin
               next_s.cas = 4'h0;
               next_s.st = drw_pkg::ST_CHG;
               next_s.step = {1'b0, s.pre};
               next_s.pend = 1'b0;
               inc = s.addr + 1'b1;
               next_s.addr = s.dual ? inc
                             : {2'h0, inc[drw_pkg::SP_CNT_W-1:0]};
            end
         end
         drw_pkg::ST_CHG: begin
            if (s.step == 3'h0) begin
               next_s.st = drw_pkg::ST_IDLE;
            end else begin
               next_s.step = s.step - 3'h1;
            end
         end
         default: next_s.st = drw_pkg::ST_IDLE;
      endcase
      // A request arriving as a refresh ends is kept, not lost
      if (set_pend) begin
         next_s.pend = 1'b1;
      end
   end
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Outputs and wait generator
   assign bus.refresh_in_progress = s.st == drw_pkg::ST_PRE ||
                                    s.st == drw_pkg::ST_LOW;
   assign bus.ras_b = ~s.on;
   assign bus.cas_b = ~s.cas;
   assign refresh_addr_o = s.addr;
   assign hold_w = s.st != drw_pkg::ST_IDLE || bus.extra_wait_in ||
                   !bus.port_b_grant;
   drw_wait drw_wait_i (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .ack_mode_i(s.ack_mode),
      .delay_i(s.dly),
      .page_i(s.page),
      .access_i(bus.access_request_in),
      .cas_en_i(bus.cas_enable_in),
      .hold_i(hold_w),
      .wait_o(wait_o)
   );
   assign bus.transfer_acknowledge_out = wait_o;
endmodule

// [rtl/drw_host.sv]
// CPU-side end: drives access, refresh and extension requests
`timescale 1ns/1ps
module drw_host (
   drw_if.host bus,
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic access_i,
   input wire logic cas_en_i,
   input wire logic extra_wait_i,
   input wire logic grant_i,
   input wire logic extend_i,
   input wire logic refresh_req_i,
   input wire logic disable_auto_i,
   input wire logic correct_i,
   output logic ready_o
);
   typedef struct packed {
      logic [7:0] drv;
   } drw_hst_t;
   drw_hst_t s;
   drw_hst_t next_s;
   ////////////////////////////////////////////////////////////////////////
   // Register user orders onto the link; write only during extension
   always_comb begin
      next_s = s;
      next_s.drv = {access_i, cas_en_i, extra_wait_i, grant_i,
                    extend_i && bus.refresh_in_progress,
                    refresh_req_i, disable_auto_i,
                    correct_i && extend_i && bus.refresh_in_progress};
      // Write enable is dropped whenever extension ends
      if (!next_s.drv[3]) begin
         next_s.drv[0] = 1'b0;
      end
   end
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
   assign bus.access_request_in = s.drv[7];
   assign bus.cas_enable_in = s.drv[6];
   assign bus.extra_wait_in = s.drv[5];
   assign bus.port_b_grant = s.drv[4];
   assign bus.extend_refresh_in = s.drv[3];
   assign bus.external_refresh_request_in = s.drv[2];
   assign bus.disable_auto_refresh_in = s.drv[1];
   assign bus.write_enable = s.drv[0];
   assign ready_o = bus.transfer_acknowledge_out;
endmodule

// [rtl/drw_if.sv]
// Interface joining the CPU/refresh logic end and the controller end
`timescale 1ns/1ps
interface drw_if;
   logic access_request_in;
   logic cas_enable_in;
   logic extra_wait_in;
   logic port_b_grant;
   logic extend_refresh_in;
   logic external_refresh_request_in;
   logic disable_auto_refresh_in;
   logic write_enable;
   logic refresh_in_progress;
   logic transfer_acknowledge_out;
   logic [3:0] ras_b;
   logic [3:0] cas_b;
   modport dev (
      input access_request_in, cas_enable_in, extra_wait_in, port_b_grant,
      input extend_refresh_in, external_refresh_request_in,
      input disable_auto_refresh_in, write_enable,
      output refresh_in_progress, transfer_acknowledge_out, ras_b, cas_b
   );
   modport host (
      output access_request_in, cas_enable_in, extra_wait_in, port_b_grant,
      output extend_refresh_in, external_refresh_request_in,
      output disable_auto_refresh_in, write_enable,
      input refresh_in_progress, transfer_acknowledge_out, ras_b, cas_b
   );
endinterface

// [rtl/drw_pkg.sv]
// Package of constants and types for the DRAM refresh and wait logic
// How it works
// - Single strobes stagger one per edge
// - Paired strobes: 0,1 then 2,3
// - All strobes assert on first edge
// - Scrubbing only non-staggered, chosen by configuration
// - Scrub refresh asserts column strobes during rows
// - Far logic may extend and drive write
// - Refresh address counter is 22 or 24 bits
// - Counter order bank, column, row low
// - Bank bits pick scrub column strobes
// - Only all-row refresh may be extended
// - Extend sampled each edge until low
// - External request without disable clears counter
// - Request then disable gives back-to-back refresh
// - 500 ns request clears timer and counter
// - Wait while precharge, refresh, count, input, grant
// - Type bit selects wait or acknowledge
// - Wait asserts at start, negates after count
// - Page mode: wait follows column enable
// - Wait stays negated after access ends
// - Acknowledge asserts after programmed count
// - Page mode: acknowledge toggles with column enable
// - Acknowledge negates when access ends
// - Refresh in progress one clock before strobes
package drw_pkg;
   localparam int CNT_W = 24;
   localparam int ROW_W = 11;
   localparam int COL_W = 11;
   localparam int ROW_LSB = 0;
   localparam int COL_LSB = ROW_W;
   localparam int BANK_LSB = ROW_W + COL_W;
   localparam int SP_CNT_W = 22;
   localparam int SP_BANK_LSB = 20;
   localparam logic [CNT_W-1:0] CNT_RST = 24'h000000;
   localparam int CLK_NS = 50;
   localparam int CLR_NS = 500;
   localparam int CLR_CYC = (CLR_NS + CLK_NS - 1) / CLK_NS;
   localparam int REF_US = 15;
   localparam int REF_CYC = REF_US * 1000 / CLK_NS;
   localparam logic [1:0] RAS_SINGLE = 2'h0;
   localparam logic [1:0] RAS_PAIR = 2'h1;
   localparam logic [1:0] RAS_ALL = 2'h2;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_PRE = 2'b01,
      ST_LOW = 2'b10,
      ST_CHG = 2'b11
   } drw_ref_t;
endpackage

// [rtl/drw_wait.sv]
// Wait or acknowledge output generator
`timescale 1ns/1ps
module drw_wait (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic ack_mode_i,
   input wire logic [1:0] delay_i,
   input wire logic page_i,
   input wire logic access_i,
   input wire logic cas_en_i,
   input wire logic hold_i,
   output logic wait_o
);
   typedef struct packed {
      logic act;
      logic [2:0] cnt;
      logic done;
      logic out;
   } drw_wst_t;
   drw_wst_t s;
   drw_wst_t next_s;
   ////////////////////////////////////////////////////////////////////////
   // Count edges from access start, hold while a cause of wait stands
   always_comb begin
      next_s = s;
      if (!access_i) begin
         next_s = '0;
      end else if (!s.act) begin
         next_s.act = 1'b1;
         next_s.cnt = 3'h0;
      end else if (!s.done) begin
         if (!hold_i) begin
            if (s.cnt >= {1'b0, delay_i}) begin
               next_s.done = 1'b1;
            end else begin
               next_s.cnt = s.cnt + 3'h1;
            end
         end
      end
      // Ready level: done and, in page mode, column enable active
      next_s.out = next_s.done && (!page_i || cas_en_i);
      if (hold_i) begin
         next_s.out = 1'b0;
      end
   end
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
   // Wait style: high means wait; ack style: high means acknowledge
   always_comb begin
      if (ack_mode_i) begin
         wait_o = s.out;
      end else begin
         wait_o = s.act && !s.out ? 1'b1 : 1'b0;
      end
   end
endmodule

// [testbench/dram_refresh_and_wait_logic_test.sv]
// Testbench joining both ends and checking refresh and wait behaviour
`timescale 1ns/1ps
module dram_refresh_and_wait_logic_test;
   logic clk_i, rst_b_i, prog, stag, wtype, acc, xw, gnt, ext, rreq, dis, cor;
   logic pg, cen;
   logic [2:0] cfg;
   logic [1:0] wdel;
   logic [23:0] addr;
   logic wait_w, rdy;
   logic [7:0] n;
   logic [3:0] p1, p2;
   logic nc;
   int mismatches, num_checks, k, m, d;
   localparam logic [2:0] T_CFG [4] = '{3'h4, 3'h5, 3'h7, 3'h3};
   localparam logic T_STG [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
   localparam int T_EXT [4] = '{3, 0, 0, 3};
   localparam logic [3:0] T_P1 [4] = '{4'he, 4'hc, 4'h0, 4'h0};
   localparam logic [3:0] T_P2 [4] = '{4'hc, 4'h0, 4'h0, 4'h0};
   localparam logic [7:0] T_N [4] = '{8'h05, 8'h03, 8'h02, 8'h05};
   localparam logic T_SC [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
   drw_if bus_i();
   drw_dev drw_dev_i(.bus(bus_i), .clk_i(clk_i), .rst_b_i(rst_b_i),
      .prog_i(prog), .ras_cas_config_bits_i(cfg),
      .staggered_select_bit_i(stag), .ras_low_i(2'h1), .precharge_i(2'h1),
      .wait_type_select_bit_i(wtype), .wait_delay_bits_i(wdel),
      .page_mode_i(pg), .dual_port_i(1'b1), .refresh_addr_o(addr),
      .wait_o(wait_w));
   drw_host drw_host_i(.bus(bus_i), .clk_i(clk_i), .rst_b_i(rst_b_i),
      .access_i(acc), .cas_en_i(cen), .extra_wait_i(xw), .grant_i(gnt),
      .extend_i(ext), .refresh_req_i(rreq), .disable_auto_i(dis),
      .correct_i(cor), .ready_o(rdy));
   drw_chk drw_chk_i(.clk_i(clk_i), .rst_b_i(rst_b_i),
      .access_request_in(bus_i.access_request_in),
      .extend_refresh_in(bus_i.extend_refresh_in),
      .write_enable(bus_i.write_enable),
      .refresh_in_progress(bus_i.refresh_in_progress),
      .transfer_acknowledge_out(bus_i.transfer_acknowledge_out),
      .ras_b(bus_i.ras_b), .cas_b(bus_i.cas_b));
   ////////////////////////////////////////////////////////////////////////
   // Clock source
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   // Comparison, verdict and closing
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Latch a configuration into the controller
   task automatic prog_cfg(input logic [2:0] c, input logic s,
      input logic w, input logic [1:0] dl);
      @(posedge clk_i);
      cfg <= c;
      stag <= s;
      wtype <= w;
      wdel <= dl;
      prog <= 1'b1;
      @(posedge clk_i);
      prog <= 1'b0;
   endtask
   // Watch one refresh, optionally stretching it from the host side
   task automatic ref_run(input int e, output logic [7:0] cnt,
      output logic [3:0] q1, output logic [3:0] q2, output logic sc);
      logic [23:0] a0;
      int i, j;
      cnt = 0;
      sc = 0;
      q1 = 4'hf;
      q2 = 4'hf;
      a0 = addr;
      fork
         begin
            for (i = 0; i < 400 && bus_i.ras_b === 4'hf; i++) @(negedge clk_i);
            if (i == 400) begin
               chk(24'(i), 24'h0);
               tally_and_finish();
            end
            for (i = 0; i < 40 && bus_i.ras_b !== 4'hf; i++) begin
               if (i == 0) q1 = bus_i.ras_b;
               if (i == 1) q2 = bus_i.ras_b;
               cnt++;
               sc |= (bus_i.cas_b != 4'hf);
               @(negedge clk_i);
            end
         end
         if (e > 0) begin
            for (j = 0; j < 400 && bus_i.refresh_in_progress !== 1'b1; j++)
               @(negedge clk_i);
            @(posedge clk_i);
            ext <= 1'b1;
            cor <= 1'b1;
            repeat (e) @(posedge clk_i);
            ext <= 1'b0;
            cor <= 1'b0;
         end
      join
      @(negedge clk_i);
      chk(addr, a0 + 24'h1);
   endtask
   // One access; counts samples where the CPU is held off
   task automatic acc_run(input logic md, output logic [7:0] cnt);
      int i;
      cnt = 0;
      @(posedge clk_i);
      acc <= 1'b1;
      repeat (2) @(posedge clk_i);
      for (i = 0; i < 10; i++) begin
         @(negedge clk_i);
         if (wait_w !== ~md) break;
         cnt++;
      end
      @(posedge clk_i);
      acc <= 1'b0;
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      chk(24'({rdy, wait_w}), 24'h0);
   endtask
   // Main sequence
   initial begin
      {prog, stag, wtype, acc, xw, ext, rreq, dis, cor, pg} = '0;
      gnt = 1'b1;
      cen = 1'b1;
      cfg = 3'h3;
      wdel = 2'h0;
      rst_b_i = 1'b0;
      repeat (20) @(posedge clk_i);
      rst_b_i <= 1'b1;
      prog_cfg(3'h3, 1'b0, 1'b0, 2'h0);
      // Request a clock before disable: clear, then back-to-back refresh
      @(posedge clk_i);
      rreq <= 1'b1;
      @(posedge clk_i);
      dis <= 1'b1;
      @(posedge clk_i);
      @(negedge clk_i);
      chk(addr, 24'h0);
      for (k = 0; k < 2; k++) begin
         ref_run(0, n, p1, p2, nc);
         chk(24'({p1, n}), 24'h002);
      end
      @(posedge clk_i);
      rreq <= 1'b0;
      repeat (30) @(posedge clk_i);
      // Refresh types, scrubbing and extension
      for (k = 0; k < 4; k++) begin
         prog_cfg(T_CFG[k], T_STG[k], 1'b0, 2'h0);
         @(posedge clk_i);
         rreq <= 1'b1;
         @(posedge clk_i);
         rreq <= 1'b0;
         ref_run(T_EXT[k], n, p1, p2, nc);
         chk(24'(p1), 24'(T_P1[k]));
         chk(24'(p2), 24'(T_P2[k]));
         chk(24'(n), 24'(T_N[k]));
         chk(24'(nc), 24'(T_SC[k]));
         repeat (10) @(posedge clk_i);
      end
      // Wait and acknowledge styles at every delay
      for (m = 0; m < 2; m++) begin
         for (d = 0; d < 4; d++) begin
            prog_cfg(3'h3, 1'b0, m[0], d[1:0]);
            acc_run(m[0], n);
            chk(24'(n), 24'(d + 1));
         end
      end
      // Page mode: the ready output follows column enable
      @(posedge clk_i);
      pg <= 1'b1;
      for (m = 0; m < 2; m++) begin
         prog_cfg(3'h3, 1'b0, m[0], 2'h0);
         acc <= 1'b1;
         repeat (4) @(posedge clk_i);
         cen <= 1'b0;
         repeat (2) @(posedge clk_i);
         @(negedge clk_i);
         chk(24'({rdy, wait_w}), 24'({2{!m[0]}}));
         @(posedge clk_i);
         cen <= 1'b1;
         repeat (2) @(posedge clk_i);
         @(negedge clk_i);
         chk(24'({rdy, wait_w}), 24'({2{m[0]}}));
         @(posedge clk_i);
         acc <= 1'b0;
      end
      pg <= 1'b0;
      // Extra wait and invalid grant hold the CPU off
      @(posedge clk_i);
      xw <= 1'b1;
      acc_run(1'b1, n);
      chk(24'(n), 24'h0a);
      @(posedge clk_i);
      xw <= 1'b0;
      gnt <= 1'b0;
      acc_run(1'b1, n);
      chk(24'(n), 24'h0a);
      // Long request with auto refresh on clears timer and counter
      @(posedge clk_i);
      gnt <= 1'b1;
      dis <= 1'b0;
      rreq <= 1'b1;
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      chk(addr, 24'h0);
      repeat (12) @(posedge clk_i);
      rreq <= 1'b0;
      repeat (30) @(posedge clk_i);
      for (k = 0; k < drw_pkg::REF_CYC - 40; k++) begin
         @(negedge clk_i);
         if (bus_i.refresh_in_progress === 1'b1) break;
      end
      chk(24'(k), 24'(drw_pkg::REF_CYC - 40));
      for (k = 0; k < 100 && bus_i.refresh_in_progress !== 1'b1; k++)
         @(negedge clk_i);
      chk(24'(k < 100), 24'h1);
      tally_and_finish();
   end
endmodule

// [testbench/drw_chk.sv]
// Concurrent checks on the link between the host end and controller end
`timescale 1ns/1ps
module drw_chk (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic access_request_in,
   input wire logic extend_refresh_in,
   input wire logic write_enable,
   input wire logic refresh_in_progress,
   input wire logic transfer_acknowledge_out,
   input wire logic [3:0] ras_b,
   input wire logic [3:0] cas_b
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);
   ////////////////////////////////////////////////////////////////////////
   // Row strobes only inside a refresh, announced one clock ahead
   a_ras_in_refresh: assert property (
      ras_b != 4'hf |-> refresh_in_progress)
      else $error("row strobe low outside refresh");
   a_refresh_in_progress_leads_ras: assert property (
      (ras_b != 4'hf && $past(ras_b) == 4'hf) |-> $past(refresh_in_progress))
      else $error("row strobe low without a clock of notice");
   a_ras_low_bounded: assert property (
      ras_b != 4'hf |-> ##[1:40] ras_b == 4'hf)
      else $error("row strobe held far too long");
   // Scrub column strobes sit inside the all-row window
   a_scrub_cas_ras: assert property (
      cas_b != 4'hf |-> ras_b == 4'h0)
      else $error("column strobe low outside all-row window");
   a_scrub_cas_steady: assert property (
      (cas_b != 4'hf && $past(cas_b) != 4'hf) |-> cas_b == $past(cas_b))
      else $error("scrub column group changed in mid refresh");
   // Extension keeps all rows low for one more edge
   a_extend_holds: assert property (
      (ras_b == 4'h0 && extend_refresh_in) |=> ras_b == 4'h0)
      else $error("extension sampled high but strobes released");
   // Ready output falls back once the access has ended
   a_wait_drops: assert property (
      (!access_request_in && !refresh_in_progress) |=>
      (!transfer_acknowledge_out || refresh_in_progress))
      else $error("wait output active with no access");
   a_write_released: assert property (
      write_enable |-> extend_refresh_in)
      else $error("write enable left high after extension");
   // Main scenarios
   c_extended: cover property (ras_b == 4'h0 && extend_refresh_in);
   c_scrub: cover property (cas_b != 4'hf);
   c_access_end: cover property ($fell(access_request_in));
   c_write: cover property ($rose(write_enable));
endmodule
